/* inc/ral_params.svh */
// Purpose: Timing counts, field values and pin codes of the ROM autoboot loader
// Assumes: 250 MHz core clock
// Notes:   Cycle counts derive from the times in their own units
`ifndef RAL_PARAMS_SVH
`define RAL_PARAMS_SVH

`define RAL_CLK_PERIOD_PS 4000
// Least times round up to whole cycles
`define RAL_ADDR_PHASE_NS 40
`define RAL_ADDR_PHASE_CYC ((`RAL_ADDR_PHASE_NS * 1000 + `RAL_CLK_PERIOD_PS - 1) / `RAL_CLK_PERIOD_PS)
`define RAL_ROM_ACCESS_NS 330
`define RAL_ROM_ACCESS_CYC ((`RAL_ROM_ACCESS_NS * 1000 + `RAL_CLK_PERIOD_PS - 1) / `RAL_CLK_PERIOD_PS)
// Covers the registered strobe and the pin synchroniser
`define RAL_DATA_MARGIN_CYC 5
`define RAL_DATA_PHASE_CYC (`RAL_ROM_ACCESS_CYC + `RAL_DATA_MARGIN_CYC)
// Longest time rounds down
`define RAL_BOOT_LIMIT_MS 175
// Divide first so the product stays inside 32-bit arithmetic
`define RAL_BOOT_LIMIT_CYC (`RAL_BOOT_LIMIT_MS * (1000000000 / `RAL_CLK_PERIOD_PS))
`define RAL_PREP_CYC 16
`define RAL_IRESET_CYC 4
`define RAL_IMAGE_BYTES 32768
`define RAL_ADDR_BYTES 3
`define RAL_ADDR_TOP_BYTE 8'h00
`define RAL_WRONG_PART_BYTE 8'hF0
// Arbitrary value
`define RAL_VARIANT_TAG 8'h5A
// Mode pin codes {wr, rd} that select a serial host; bit n set means code n is serial
`define RAL_SERIAL_MODES 4'h3

`endif

/* inc/ral_pkg.sv */
// Purpose: Types of the ROM autoboot loader
// Assumes: Nothing
// Notes:   Constants live in ral_params.svh
package ral_pkg;

   typedef enum logic [3:0] {
      ST_CAPTURE,
      ST_IDLE,
      ST_PREP,
      ST_ADDR_LOW,
      ST_ADDR_HIGH,
      ST_DATA,
      ST_RECOVER,
      ST_INT_RESET,
      ST_WAIT_LAUNCH,
      ST_DECODE,
      ST_FAIL
   } ral_state_type;

   typedef struct packed {
      logic [7:0] addrData;
      logic addrDataOe;
      logic outputEnableStrobeN;
      logic selectN;
   } ral_mem_bus_type;

   typedef struct packed {
      logic valid;
      logic [14:0] addr;
      logic [7:0] data;
   } ral_load_type;

endpackage

/* core/ral_pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs change slowly against the clock
// Notes:   Data flops carry no reset so levels are valid at reset release
`timescale 1ns/1ps
`default_nettype none

module ral_pin_sync #(
   parameter int WIDTH = 11
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // ------------------------------------------------------------
   // Per-bit chain
   // ------------------------------------------------------------
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
         stage1[i] <= pinIn[i];
         stage2[i] <= stage1[i];
         stage3[i] <= stage2[i];
         if (stage2[i] == stage3[i]) begin
            level[i] <= stage3[i];
         end
      end
   end

endmodule

`default_nettype wire

/* core/ral_loader.sv */
// Purpose: Self-loads the application image from a byte-wide ROM behind two address latches
// Assumes: 250 MHz clk; shared request pin has an external pull-up
// Notes:   Loaded bytes leave as a stream towards program memory
//
// How it works
// - Request and both mode pin levels are caught when reset releases.
// - Low request with serial mode selected starts self-loading.
// - Parallel host mode never self-loads; bus pins are shared.
// - Shared pin is request input in reset, interrupt output after.
// - Eight memory pins carry address and data bytes time-multiplexed.
// - Three strobe rising edges latch address; fourth low pulse reads ROM.
// - With select and strobe low the bus pins become inputs.
// - Address is 24 bits, high byte first, upper bits zero.
// - Only 15 address bits matter; image fits 32 Kilobyte.
// - Line stays released while preparing, held low for the whole download.
// - Load end gives an internal reset which releases the interrupt line.
// - Whole sequence ends within 175 ms of reset release.
// - Image for another variant reports the wrong-part byte.
// - After a good load the block waits for the launch message.
`timescale 1ns/1ps
`default_nettype none
`include "ral_params.svh"

module ral_loader
   import ral_pkg::*;
#(
   parameter int IMAGE_BYTES = `RAL_IMAGE_BYTES,
   parameter int BOOT_LIMIT_CYC = `RAL_BOOT_LIMIT_CYC,
   parameter logic [7:0] VARIANT_TAG = `RAL_VARIANT_TAG,
   parameter logic [3:0] SERIAL_MODES = `RAL_SERIAL_MODES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic autobootRequestNIn,
   output logic hostInterruptRequestNOut,
   output logic hostInterruptRequestNOe,
   input wire logic hostStrobeModeWr,
   input wire logic hostStrobeModeRd,
   input wire logic [7:0] extMemAddrDataIn,
   output ral_mem_bus_type memBus,
   output ral_load_type load,
   input wire logic decodeLaunchMessage,
   output logic internalResetN,
   output logic decodeActive,
   output logic hostReplyValid,
   output logic [7:0] hostReplyByte
);

   localparam int PHASE_W = 7;
   localparam logic [PHASE_W-1:0] ADDR_LAST = PHASE_W'(`RAL_ADDR_PHASE_CYC - 1);
   localparam logic [PHASE_W-1:0] DATA_LAST = PHASE_W'(`RAL_DATA_PHASE_CYC - 1);
   localparam logic [PHASE_W-1:0] PREP_LAST = PHASE_W'(`RAL_PREP_CYC - 1);
   localparam logic [PHASE_W-1:0] IRESET_LAST = PHASE_W'(`RAL_IRESET_CYC - 1);
   localparam logic [1:0] ADDR_BYTE_LAST = 2'(`RAL_ADDR_BYTES - 1);
   localparam logic [14:0] IMAGE_LAST = 15'(IMAGE_BYTES - 1);
   localparam logic [25:0] LIMIT_LAST = 26'(BOOT_LIMIT_CYC - 1);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (IMAGE_BYTES < 2 || IMAGE_BYTES > `RAL_IMAGE_BYTES) begin : g_bad_image
      $error("IMAGE_BYTES must lie in 2..32768");
   end
   if (BOOT_LIMIT_CYC < 2 || BOOT_LIMIT_CYC > 67108864) begin : g_bad_limit
      $error("BOOT_LIMIT_CYC must fit the 26-bit watchdog");
   end
   if (`RAL_DATA_PHASE_CYC > 127) begin : g_bad_phase
      $error("Data phase does not fit the phase counter");
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [10:0] pinLevel;
   logic requestLevelN;
   logic [1:0] modeLevel;
   logic [7:0] romByte;

   ral_pin_sync #(
      .WIDTH(11)
   ) u_sync (
      .clk(clk),
      .pinIn({autobootRequestNIn, hostStrobeModeWr, hostStrobeModeRd, extMemAddrDataIn}),
      .level(pinLevel)
   );

   assign requestLevelN = pinLevel[10];
   assign modeLevel = pinLevel[9:8];
   assign romByte = pinLevel[7:0];

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   ral_state_type state;
   logic [PHASE_W-1:0] phaseCount;
   logic [1:0] byteIndex;
   logic [14:0] fetchAddr;
   logic [25:0] watchdog;
   logic loading;
   logic dataDone;

   assign loading = state inside {ST_ADDR_LOW, ST_ADDR_HIGH, ST_DATA, ST_RECOVER};
   assign dataDone = (state == ST_DATA) && (phaseCount == DATA_LAST);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_CAPTURE;
         phaseCount <= '0;
         byteIndex <= '0;
         fetchAddr <= '0;
      end else begin
         phaseCount <= phaseCount + PHASE_W'(1);
         unique case (state)
            ST_CAPTURE: begin
               // First edge after release sees the levels held at release
               phaseCount <= '0;
               if (!requestLevelN && SERIAL_MODES[modeLevel]) begin
                  state <= ST_PREP;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               phaseCount <= '0;
            end
            ST_PREP: begin
               if (phaseCount == PREP_LAST) begin
                  state <= ST_ADDR_LOW;
                  phaseCount <= '0;
                  byteIndex <= '0;
                  fetchAddr <= '0;
               end
            end
            ST_ADDR_LOW: begin
               if (phaseCount == ADDR_LAST) begin
                  state <= ST_ADDR_HIGH;
                  phaseCount <= '0;
               end
            end
            ST_ADDR_HIGH: begin
               if (phaseCount == ADDR_LAST) begin
                  phaseCount <= '0;
                  if (byteIndex == ADDR_BYTE_LAST) begin
                     state <= ST_DATA;
                  end else begin
                     byteIndex <= byteIndex + 2'd1;
                     state <= ST_ADDR_LOW;
                  end
               end
            end
            ST_DATA: begin
               if (dataDone) begin
                  phaseCount <= '0;
                  if (fetchAddr == '0 && romByte != VARIANT_TAG) begin
                     state <= ST_FAIL;
                  end else if (fetchAddr == IMAGE_LAST) begin
                     state <= ST_INT_RESET;
                  end else begin
                     state <= ST_RECOVER;
                  end
               end
            end
            ST_RECOVER: begin
               if (phaseCount == ADDR_LAST) begin
                  state <= ST_ADDR_LOW;
                  phaseCount <= '0;
                  byteIndex <= '0;
                  fetchAddr <= fetchAddr + 15'd1;
               end
            end
            ST_INT_RESET: begin
               if (phaseCount == IRESET_LAST) begin
                  state <= ST_WAIT_LAUNCH;
               end
            end
            ST_WAIT_LAUNCH: begin
               if (decodeLaunchMessage) begin
                  state <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               phaseCount <= '0;
            end
            ST_FAIL: begin
               phaseCount <= '0;
            end
         endcase
         // Overrun of the boot budget ends the load as a failure
         if (loading && watchdog >= LIMIT_LAST) begin
            state <= ST_FAIL;
         end
      end
   end

   // ------------------------------------------------------------
   // Boot budget watchdog
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdog <= '0;
      end else if (state == ST_PREP || loading) begin
         watchdog <= watchdog + 26'd1;
      end
   end

   // ------------------------------------------------------------
   // Memory bus pins
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         memBus.addrData <= 8'h00;
         memBus.addrDataOe <= 1'b0;
         memBus.outputEnableStrobeN <= 1'b1;
         memBus.selectN <= 1'b1;
      end else begin
         // Address bytes go out high first on the shared pins
         unique case (byteIndex)
            2'd0: memBus.addrData <= `RAL_ADDR_TOP_BYTE;
            2'd1: memBus.addrData <= {1'b0, fetchAddr[14:8]};
            default: memBus.addrData <= fetchAddr[7:0];
         endcase
         memBus.addrDataOe <= state inside {ST_ADDR_LOW, ST_ADDR_HIGH};
         memBus.outputEnableStrobeN <= !(state inside {ST_ADDR_LOW, ST_DATA});
         memBus.selectN <= !(state == ST_DATA);
      end
   end

   // ------------------------------------------------------------
   // Shared request / interrupt pin
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hostInterruptRequestNOut <= 1'b0;
         hostInterruptRequestNOe <= 1'b0;
      end else begin
         hostInterruptRequestNOut <= 1'b0;
         // Released while preparing, low through download or a failed load
         hostInterruptRequestNOe <= loading || state == ST_FAIL;
      end
   end

   // ------------------------------------------------------------
   // Load stream and status
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load <= '0;
      end else begin
         load.valid <= dataDone;
         if (dataDone) begin
            load.addr <= fetchAddr;
            load.data <= romByte;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         internalResetN <= 1'b1;
         decodeActive <= 1'b0;
         hostReplyValid <= 1'b0;
         hostReplyByte <= 8'h00;
      end else begin
         internalResetN <= !(state == ST_INT_RESET);
         decodeActive <= state == ST_DECODE;
         hostReplyValid <= state == ST_FAIL;
         hostReplyByte <= (state == ST_FAIL) ? `RAL_WRONG_PART_BYTE : 8'h00;
      end
   end

endmodule

`default_nettype wire

/* bench/ral_rom_model.sv */
// Purpose: Byte-wide ROM behind two cascaded address latches
// Assumes: Latches clock on the rising strobe edge
// Notes:   A third latch copy exposes the dropped top address byte
`timescale 1ns/1ps
`default_nettype none
module ral_rom_model
   import ral_pkg::*;
#(
   parameter int ACCESS_NS = 0
) (
   input wire ral_mem_bus_type memBus,
   input wire logic [31:0] image,
   output logic [7:0] pins,
   output logic [7:0] topSeen
);
   logic [7:0] lowLatch = 8'h00;
   logic [7:0] highLatch = 8'h00;
   logic [7:0] topLatch = 8'h00;
   logic [14:0] romAddr;
   logic romOn = 1'b0;
   always @(posedge memBus.outputEnableStrobeN) begin
      topLatch <= highLatch;
      highLatch <= lowLatch;
      lowLatch <= pins;
   end
   always @(negedge memBus.selectN) topSeen <= topLatch;
   always @(memBus.selectN or memBus.outputEnableStrobeN) begin
      if (memBus.selectN || memBus.outputEnableStrobeN) romOn = 1'b0;
      else romOn <= #(ACCESS_NS) 1'b1;
   end
   assign romAddr = {highLatch[6:0], lowLatch};
   // Released bus shows the inverse of the last latched byte
   assign pins = memBus.addrDataOe ? memBus.addrData :
      romOn ? ((romAddr < 15'h4) ? image[8 * romAddr[1:0] +: 8] : ~romAddr[7:0]) : ~lowLatch;
endmodule
`default_nettype wire

/* bench/ral_loader_assertions.sv */
// Purpose: Port assertions of the ROM autoboot loader
// Assumes: One clock domain
// Notes:   Bound into ral_loader
`timescale 1ns/1ps
`default_nettype none
module ral_loader_assertions
   import ral_pkg::*;
#(
   parameter int BOOT_LIMIT_CYC = 20000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hostInterruptRequestNOut,
   input wire logic hostInterruptRequestNOe,
   input wire ral_mem_bus_type memBus,
   input wire ral_load_type load,
   input wire logic decodeLaunchMessage,
   input wire logic internalResetN,
   input wire logic decodeActive,
   input wire logic hostReplyValid,
   input wire logic [7:0] hostReplyByte
);
   logic [31:0] sinceReset;
   logic [1:0] addrRises;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sinceReset <= 32'h0;
      else if (sinceReset != 32'hFFFFFFFF) sinceReset <= sinceReset + 32'h1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) addrRises <= 2'h0;
      else if (!memBus.selectN) addrRises <= 2'h0;
      else if (memBus.addrDataOe && $rose(memBus.outputEnableStrobeN)) addrRises <= addrRises + 2'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   open_drain_a: assert property (hostInterruptRequestNOut == 1'b0) else $error("shared pin driven high");
   bus_release_a: assert property (!memBus.selectN && !memBus.outputEnableStrobeN |-> !memBus.addrDataOe)
      else $error("bus driven during read");
   three_addr_a: assert property ($fell(memBus.selectN) |-> addrRises == 2'h3) else $error("address edges not three");
   prep_quiet_a: assert property (hostInterruptRequestNOe |-> sinceReset >= 32'd16) else $error("line low during prep");
   load_low_a: assert property (load.valid |-> hostInterruptRequestNOe) else $error("line high during load");
   ireset_width_a: assert property ($fell(internalResetN) |-> (!internalResetN) [*4] ##1 internalResetN)
      else $error("internal reset width");
   ireset_release_a: assert property ($fell(internalResetN) |-> !hostInterruptRequestNOe)
      else $error("line not released");
   boot_limit_a: assert property ($fell(internalResetN) |-> sinceReset < 32'(BOOT_LIMIT_CYC))
      else $error("boot too long");
   launch_cause_a: assert property ($rose(decodeActive) |-> $past(decodeLaunchMessage, 2)
      || $past(decodeLaunchMessage, 3)) else $error("decode without launch");
   reply_byte_a: assert property (hostReplyValid |-> hostReplyByte == 8'hF0) else $error("reply byte");
   cover property (load.valid);
   cover property ($rose(hostReplyValid));
   cover property ($rose(decodeActive));
endmodule
bind ral_loader ral_loader_assertions #(.BOOT_LIMIT_CYC(BOOT_LIMIT_CYC)) u_ral_loader_assertions (
   .clk(clk), .rst_n(rst_n), .hostInterruptRequestNOut(hostInterruptRequestNOut),
   .hostInterruptRequestNOe(hostInterruptRequestNOe), .memBus(memBus), .load(load),
   .decodeLaunchMessage(decodeLaunchMessage), .internalResetN(internalResetN), .decodeActive(decodeActive),
   .hostReplyValid(hostReplyValid), .hostReplyByte(hostReplyByte));
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: Self-checking bench of the ROM autoboot loader
// Assumes: Four-byte image, short boot limit
// Notes:   Expected load stream kept in a queue
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ral_pkg::*;
();
   logic clk, rst_n, hostPull, modeWr, modeRd, launch, oeSeen;
   logic intOut, intOe, iresetN, decodeActive, replyValid;
   logic [7:0] pins, topSeen, replyByte;
   logic [31:0] image, rng;
   logic [22:0] expEntry;
   logic [22:0] expQ[$];
   ral_mem_bus_type memBus;
   ral_load_type load;
   wire intWire;
   int bad_count = 0;
   int checks_done = 0;
   int loadCount;
   // Pull-up wire, open-drain host
   assign intWire = (hostPull || (intOe && !intOut)) ? 1'b0 : 1'b1;
   ral_loader #(.IMAGE_BYTES(4), .BOOT_LIMIT_CYC(20000)) u_ral_loader (.clk(clk), .rst_n(rst_n),
      .autobootRequestNIn(intWire), .hostInterruptRequestNOut(intOut), .hostInterruptRequestNOe(intOe),
      .hostStrobeModeWr(modeWr), .hostStrobeModeRd(modeRd), .extMemAddrDataIn(pins), .memBus(memBus),
      .load(load), .decodeLaunchMessage(launch), .internalResetN(iresetN), .decodeActive(decodeActive),
      .hostReplyValid(replyValid), .hostReplyByte(replyByte));
   ral_rom_model #(.ACCESS_NS(300)) u_ral_rom_model (.memBus(memBus), .image(image), .pins(pins),
      .topSeen(topSeen));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error: %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rst_n && intOe === 1'b1) oeSeen = 1'b1;
      if (rst_n && load.valid === 1'b1) begin
         loadCount++;
         if (expQ.size() == 0) check("load extra", 1, 0);
         else begin
            expEntry = expQ.pop_front();
            check("load addr", load.addr, expEntry[22:8]);
            check("load data", load.data, expEntry[7:0]);
         end
         check("top byte", topSeen, 8'h00);
      end
   end
   task automatic runCase(input logic [1:0] code, input logic req, input logic good);
      logic boot;
      int n;
      boot = !req && (code < 2'h2);
      @(negedge clk);
      rst_n = 1'b0;
      {modeWr, modeRd} = code;
      hostPull = !req;
      rng = xs(rng);
      image = {rng[31:8], good ? 8'h5A : 8'hA5};
      expQ.delete();
      loadCount = 0;
      oeSeen = 1'b0;
      if (boot) for (n = 0; n < 4; n++) expQ.push_back({15'(n), image[8 * n +: 8]});
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      hostPull = 1'b0;
      {modeWr, modeRd} = 2'h3;
      if (boot) begin
         n = 0;
         while (iresetN === 1'b1 && replyValid !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
         end
         check("boot done", n < 3000, 1);
         repeat (8) @(negedge clk);
         if (good) begin
            check("bytes loaded", loadCount, 4);
            check("line held low", oeSeen, 1);
            check("line released", intWire, 1);
            repeat (rng[3:0]) @(negedge clk);
            check("decode idle", decodeActive, 0);
            launch = 1'b1;
            repeat (4) @(negedge clk);
            launch = 1'b0;
            check("decode running", decodeActive, 1);
         end else begin
            check("reply valid", replyValid, 1);
            check("reply byte", replyByte, 8'hF0);
            check("line low on fail", intWire, 0);
         end
      end else begin
         repeat (1000) @(negedge clk);
         check("no load", loadCount, 0);
         check("line never low", oeSeen, 0);
      end
      $display("Test done: mode %0d request %0d tag %0d", code, req, good);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      hostPull = 1'b1;
      {modeWr, modeRd} = 2'h0;
      launch = 1'b0;
      image = 32'h0;
      rng = 32'h32C4;
      runCase(2'h0, 1'b0, 1'b1);
      runCase(2'h1, 1'b0, 1'b0);
      runCase(2'h2, 1'b0, 1'b1);
      runCase(2'h3, 1'b0, 1'b1);
      runCase(2'h0, 1'b1, 1'b1);
      runCase(2'h1, 1'b0, 1'b1);
      conclude();
   end
   initial begin
      #200000;
      bad_count++;
      $display("Error: watchdog expected done seen hang");
      conclude();
   end
endmodule
`default_nettype wire
